// File: core/sifb_top.sv
// top: apb slave, enable register, status, interrupt and buffer access
`timescale 1ns/1ps
module sifb_top #(
  parameter int unsigned NUM_SRC   = 20,
  parameter int unsigned BUF_WORDS = 16
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic      [31:0]          prdata,
  output logic                      pslverr,
  input  wire logic [NUM_SRC-1:0]   hw_event,
  input  wire sifb_pkg::sifb_buf_wr_t xfer_wr,
  output logic                      irq,
  output logic      [NUM_SRC-1:0]   status_out
);
  sifb_pkg::sifb_req_t    req;
  sifb_pkg::sifb_buf_wr_t sw_wr;
  logic [NUM_SRC-1:0] raw_reg;
  logic [NUM_SRC-1:0] enable_reg;
  logic [NUM_SRC-1:0] status_next;
  logic [NUM_SRC-1:0] clr_pulse;
  logic [NUM_SRC-1:0] set_pulse;
  logic               raw_we;
  logic               access;
  logic               wr_hit;
  logic               in_buf;
  logic [3:0]         buf_idx;
  logic [31:0]        buf_rdata;
  logic [31:0]        rdata_next;
  logic               slverr_next;

  if (NUM_SRC != sifb_pkg::NUM_SRC) begin
    $error("source count is fixed");
  end
  if (BUF_WORDS < 1 || BUF_WORDS > sifb_pkg::BUF_WORDS) begin
    $error("buffer words out of range");
  end

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    return a == o;
  endfunction

  assign req = '{write: pwrite, addr: paddr, wdata: pwdata};

  // access phase completes on the first edge, pready is high then
  assign access = psel && penable && pready;
  assign wr_hit = access && req.write;

  logic [11:0] buf_off;
  assign buf_off = req.addr - sifb_pkg::OFF_BUF0;
  assign in_buf  = req.addr >= sifb_pkg::OFF_BUF0 &&
                   buf_off[11:2] < 10'(BUF_WORDS) && buf_off[1:0] == 2'b00;
  assign buf_idx = buf_off[5:2];

  // write-one pulses, never stored
  assign clr_pulse = (wr_hit && hit(req.addr, sifb_pkg::OFF_CLEAR))
                     ? req.wdata[NUM_SRC-1:0] : '0;
  assign set_pulse = (wr_hit && hit(req.addr, sifb_pkg::OFF_SET))
                     ? req.wdata[NUM_SRC-1:0] : '0;
  assign raw_we    = wr_hit && hit(req.addr, sifb_pkg::OFF_RAW);

  assign sw_wr = '{we:   wr_hit && in_buf,
                   idx:  buf_idx,
                   data: req.wdata};

  sifb_flags #(
    .N (NUM_SRC)
  ) u_flags (
    .clk       (clk),
    .reset     (reset),
    .hw_event  (hw_event),
    .raw_we    (raw_we),
    .raw_wdata (req.wdata[NUM_SRC-1:0]),
    .clr_pulse (clr_pulse),
    .set_pulse (set_pulse),
    .raw_reg   (raw_reg)
  );

  sifb_buffer #(
    .WORDS (BUF_WORDS)
  ) u_buffer (
    .clk     (clk),
    .reset   (reset),
    .sw_wr   (sw_wr),
    .xfer_wr (xfer_wr),
    .rd_idx  (buf_idx),
    .rd_data (buf_rdata)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      enable_reg <= sifb_pkg::EN_RESET[NUM_SRC-1:0];
    end else if (wr_hit && hit(req.addr, sifb_pkg::OFF_ENABLE)) begin
      enable_reg <= req.wdata[NUM_SRC-1:0];
    end
  end

  // status is registered from the current raw and enable
  assign status_next = raw_reg & enable_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      status_out <= sifb_pkg::SRC_RESET[NUM_SRC-1:0];
      irq        <= 1'b0;
    end else begin
      status_out <= status_next;
      irq        <= |status_next;
    end
  end

  // no wait state: pready rises in the access phase's first cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  always_comb begin
    rdata_next  = sifb_pkg::RD_ZERO;
    slverr_next = 1'b0;
    if (in_buf) begin
      rdata_next = buf_rdata;
    end else begin
      unique case (req.addr)
        sifb_pkg::OFF_ENABLE: rdata_next = sifb_pkg::sifb_zext20(enable_reg);
        sifb_pkg::OFF_CLEAR:  rdata_next = sifb_pkg::RD_ZERO;
        sifb_pkg::OFF_RAW:    rdata_next = sifb_pkg::sifb_zext20(raw_reg);
        sifb_pkg::OFF_STATUS: begin
          rdata_next = sifb_pkg::sifb_zext20(status_next);
        end
        sifb_pkg::OFF_SET:    rdata_next = sifb_pkg::RD_ZERO;
        default:              slverr_next = 1'b1;
      endcase
    end
  end

  // read data and error are presented with pready
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata  <= sifb_pkg::RD_ZERO;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= req.write ? sifb_pkg::RD_ZERO : rdata_next;
      pslverr <= slverr_next;
    end else begin
      prdata  <= sifb_pkg::RD_ZERO;
      pslverr <= 1'b0;
    end
  end

  a_status_ro: assert property (@(posedge clk) disable iff (reset)
    (wr_hit && hit(req.addr, sifb_pkg::OFF_STATUS) && hw_event == '0)
    |=> $stable(raw_reg) && $stable(enable_reg))
    else $error("status write disturbed flags");
  a_status_and: assert property (@(posedge clk) disable iff (reset)
    ##1 status_out == $past(raw_reg & enable_reg))
    else $error("status not raw and enable");
  a_irq_any: assert property (@(posedge clk) disable iff (reset)
    irq == (status_out != '0))
    else $error("interrupt does not follow status");
  a_enable_write: assert property (@(posedge clk) disable iff (reset)
    (wr_hit && hit(req.addr, sifb_pkg::OFF_ENABLE))
    |=> enable_reg == $past(req.wdata[NUM_SRC-1:0]))
    else $error("enable write lost");
  a_raw_write: assert property (@(posedge clk) disable iff (reset)
    (raw_we && clr_pulse == '0 && set_pulse == '0 && hw_event == '0)
    |=> raw_reg == $past(req.wdata[NUM_SRC-1:0]))
    else $error("raw write lost");
  a_ready_one: assert property (@(posedge clk) disable iff (reset)
    (psel && !penable) ##1 (psel && penable) |-> pready)
    else $error("ready late");

  c_irq_rise: cover property (@(posedge clk) disable iff (reset)
    $rose(irq));
  c_clear_write: cover property (@(posedge clk) disable iff (reset)
    wr_hit && hit(req.addr, sifb_pkg::OFF_CLEAR));
  c_buf_read: cover property (@(posedge clk) disable iff (reset)
    access && !req.write && in_buf);
  c_unmapped: cover property (@(posedge clk) disable iff (reset)
    access && pslverr);
endmodule

// File: core/sifb_pkg.sv
// package: register map, source bits and carriers of the flag bank
// Operation
// - writing one to clear drops raw flag
// - raw flag per source, hardware sets, software writes
// - application flags never set by hardware
// - status per source read-only, writes ignored
// - writing one to set forces raw flag
// - error sources each have raw, clear, set, status
// - 32-bit data buffer words, software and transfer access
// - per-source writable enable register
package sifb_pkg;
  localparam int unsigned NUM_SRC  = 20;
  localparam int unsigned BUF_WORDS = 16;
  localparam int unsigned ADDR_W   = 12;

  localparam logic [11:0] OFF_ENABLE = 12'h034;
  localparam logic [11:0] OFF_CLEAR  = 12'h038;
  localparam logic [11:0] OFF_RAW    = 12'h03c;
  localparam logic [11:0] OFF_STATUS = 12'h040;
  localparam logic [11:0] OFF_SET    = 12'h044;
  localparam logic [11:0] OFF_BUF0   = 12'h098;

  localparam logic [19:0] SRC_RESET = 20'h00000;
  localparam logic [19:0] EN_RESET  = 20'h00000;
  localparam logic [31:0] BUF_RESET = 32'h00000000;
  localparam logic [31:0] RD_ZERO   = 32'h00000000;

  // bit positions of the twenty sources
  localparam int unsigned B_DMA_RX_FULL   = 0;
  localparam int unsigned B_DMA_TX_EMPTY  = 1;
  localparam int unsigned B_QUAD_EXIT     = 2;
  localparam int unsigned B_QUAD_ENTER    = 3;
  localparam int unsigned B_CMD_SEVEN     = 4;
  localparam int unsigned B_CMD_EIGHT     = 5;
  localparam int unsigned B_CMD_NINE      = 6;
  localparam int unsigned B_CMD_TEN       = 7;
  localparam int unsigned B_DMA_RD_DONE   = 8;
  localparam int unsigned B_DMA_WR_DONE   = 9;
  localparam int unsigned B_BUF_RD_DONE   = 10;
  localparam int unsigned B_BUF_WR_DONE   = 11;
  localparam int unsigned B_TRANS_DONE    = 12;
  localparam int unsigned B_SEG_DONE      = 13;
  localparam int unsigned B_MAGIC_ERR     = 14;
  localparam int unsigned B_CMD_ERR       = 15;
  localparam int unsigned B_RX_OVERFLOW   = 16;
  localparam int unsigned B_TX_UNDERFLOW  = 17;
  localparam int unsigned B_APP_TWO       = 18;
  localparam int unsigned B_APP_ONE       = 19;

  // hardware may set only bits 0..17
  localparam logic [19:0] HW_MASK = 20'h3ffff;

  typedef struct packed {
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } sifb_req_t;

  typedef struct packed {
    logic        we;
    logic [3:0]  idx;
    logic [31:0] data;
  } sifb_buf_wr_t;

  function automatic logic [31:0] sifb_zext20(input logic [19:0] v);
    return {12'h000, v};
  endfunction
endpackage

// File: core/sifb_flags.sv
// flag bank: raw flags with set, clear, write and hardware events
`timescale 1ns/1ps
module sifb_flags #(
  parameter int unsigned N = 20
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [N-1:0] hw_event,
  input  wire logic         raw_we,
  input  wire logic [N-1:0] raw_wdata,
  input  wire logic [N-1:0] clr_pulse,
  input  wire logic [N-1:0] set_pulse,
  output logic      [N-1:0] raw_reg
);
  logic [N-1:0] hw_gated;
  logic [N-1:0] raw_next;

  if (N != sifb_pkg::NUM_SRC) begin
    $error("flag bank width must match sources");
  end

  // application sources are cut off from hardware
  assign hw_gated = hw_event & sifb_pkg::HW_MASK[N-1:0];

  always_comb begin
    raw_next = raw_reg;
    if (raw_we) begin
      raw_next = raw_wdata;
    end
    raw_next = raw_next & ~clr_pulse;
    // set and events win over clear
    raw_next = raw_next | set_pulse | hw_gated;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      raw_reg <= sifb_pkg::SRC_RESET[N-1:0];
    end else begin
      raw_reg <= raw_next;
    end
  end

  a_app_no_hw: assert property (@(posedge clk) disable iff (reset)
    (!raw_we && set_pulse[N-1:N-2] == 2'b00 && raw_reg[N-1:N-2] == 2'b00)
    |=> raw_reg[N-1:N-2] == 2'b00)
    else $error("application flag set by hardware");
  a_event_sets: assert property (@(posedge clk) disable iff (reset)
    hw_gated[sifb_pkg::B_MAGIC_ERR] |=> raw_reg[sifb_pkg::B_MAGIC_ERR])
    else $error("hardware event lost");
  a_clear_drops: assert property (@(posedge clk) disable iff (reset)
    (clr_pulse[0] && !set_pulse[0] && !hw_gated[0]) |=> !raw_reg[0])
    else $error("clear did not drop flag");
  a_set_forces: assert property (@(posedge clk) disable iff (reset)
    set_pulse[sifb_pkg::B_APP_ONE] |=> raw_reg[sifb_pkg::B_APP_ONE])
    else $error("set did not force flag");
endmodule

// File: core/sifb_buffer.sv
// data buffer words written by software or by transfer logic
`timescale 1ns/1ps
module sifb_buffer #(
  parameter int unsigned WORDS = 16
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire sifb_pkg::sifb_buf_wr_t sw_wr,
  input  wire sifb_pkg::sifb_buf_wr_t xfer_wr,
  input  wire logic [3:0]             rd_idx,
  output logic      [31:0]            rd_data
);
  logic [31:0] mem_reg [WORDS];

  if (WORDS < 1 || WORDS > 16) begin
    $error("buffer depth must be 1..16");
  end

  // transfer logic wins over software in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_reg[i] <= sifb_pkg::BUF_RESET;
      end
    end else if (xfer_wr.we && 32'(xfer_wr.idx) < WORDS) begin
      mem_reg[xfer_wr.idx] <= xfer_wr.data;
    end else if (sw_wr.we && 32'(sw_wr.idx) < WORDS) begin
      mem_reg[sw_wr.idx] <= sw_wr.data;
    end
  end

  assign rd_data = (32'(rd_idx) < WORDS) ? mem_reg[rd_idx]
                                         : sifb_pkg::RD_ZERO;
endmodule

// File: dv/spi_interrupt_flag_bank_bench.sv
// self-checking bench of the spi interrupt flag bank
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("wrong value at %0t: got %h want %h", $time, got, exp); \
  end \
end
module spi_interrupt_flag_bank_bench;
  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [31:0] data;
    logic [31:0] exp;
    logic        err;
  } sifb_row_t;
  localparam logic [11:0] A_EN  = sifb_pkg::OFF_ENABLE;
  localparam logic [11:0] A_CL  = sifb_pkg::OFF_CLEAR;
  localparam logic [11:0] A_RAW = sifb_pkg::OFF_RAW;
  localparam logic [11:0] A_ST  = sifb_pkg::OFF_STATUS;
  localparam logic [11:0] A_SET = sifb_pkg::OFF_SET;
  localparam logic [11:0] A_B0  = sifb_pkg::OFF_BUF0;
  localparam int          NROWS = 22;
  logic                   clk;
  logic                   reset;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic                   pready;
  logic                   pslverr;
  logic                   irq;
  logic                   err;
  logic [11:0]            paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic [31:0]            rd;
  logic [19:0]            hw_event;
  logic [19:0]            status_out;
  sifb_pkg::sifb_buf_wr_t xfer_wr;
  int                     err_count;
  int                     samples_checked;
  int                     cycles;
  sifb_row_t              rows [NROWS];

  sifb_top #(.NUM_SRC(20), .BUF_WORDS(16)) u_sifb_top (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .hw_event(hw_event),
    .xfer_wr(xfer_wr), .irq(irq), .status_out(status_out)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      wrap_up();
    end
  end

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    `CHK(n, 1)
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
                       input logic ee);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
    `CHK(err, ee)
  endtask

  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    hw_event = 20'h0;
    xfer_wr = '0;
    err_count = 0;
    samples_checked = 0;
    cycles = 0;
    rows[0]  = '{1'b0, A_RAW, 32'h0, 32'h0, 1'b0};
    rows[1]  = '{1'b0, A_EN, 32'h0, 32'h0, 1'b0};
    rows[2]  = '{1'b0, A_ST, 32'h0, 32'h0, 1'b0};
    rows[3]  = '{1'b0, A_B0, 32'h0, 32'h0, 1'b0};
    rows[4]  = '{1'b1, A_EN, 32'hffffffff, 32'h0, 1'b0};
    rows[5]  = '{1'b0, A_EN, 32'h0, 32'h000fffff, 1'b0};
    rows[6]  = '{1'b1, A_RAW, 32'h000a5a5a, 32'h0, 1'b0};
    rows[7]  = '{1'b0, A_RAW, 32'h0, 32'h000a5a5a, 1'b0};
    rows[8]  = '{1'b0, A_ST, 32'h0, 32'h000a5a5a, 1'b0};
    rows[9]  = '{1'b1, A_CL, 32'h0000000a, 32'h0, 1'b0};
    rows[10] = '{1'b0, A_RAW, 32'h0, 32'h000a5a50, 1'b0};
    rows[11] = '{1'b0, A_CL, 32'h0, 32'h0, 1'b0};
    rows[12] = '{1'b1, A_SET, 32'h000c0001, 32'h0, 1'b0};
    rows[13] = '{1'b0, A_RAW, 32'h0, 32'h000e5a51, 1'b0};
    rows[14] = '{1'b0, A_SET, 32'h0, 32'h0, 1'b0};
    rows[15] = '{1'b1, A_ST, 32'hffffffff, 32'h0, 1'b0};
    rows[16] = '{1'b0, A_ST, 32'h0, 32'h000e5a51, 1'b0};
    rows[17] = '{1'b1, A_EN, 32'h0000ffff, 32'h0, 1'b0};
    rows[18] = '{1'b0, A_ST, 32'h0, 32'h00005a51, 1'b0};
    rows[19] = '{1'b1, 12'h0d4, 32'hdeadbeef, 32'h0, 1'b0};
    rows[20] = '{1'b0, 12'h0d4, 32'h0, 32'hdeadbeef, 1'b0};
    rows[21] = '{1'b0, 12'hffc, 32'h0, 32'h0, 1'b1};
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    `CHK({irq, pready, pslverr, status_out}, 23'h0)
    for (int i = 0; i < NROWS; i++) begin
      apb(rows[i].wr, rows[i].addr, rows[i].data);
      if (!rows[i].wr) begin
        `CHK(rd, rows[i].exp)
        `CHK(err, rows[i].err)
      end
    end
    // hardware events on every source, application bits ignored
    apb(1'b1, A_RAW, 32'h0);
    apb(1'b1, A_EN, 32'h000fffff);
    hw_event <= 20'hfffff;
    @(posedge clk);
    hw_event <= 20'h0;
    repeat (3) @(posedge clk);
    `CHK(status_out, 20'h3ffff)
    `CHK(irq, 1'b1)
    rdchk(A_RAW, 32'h0003ffff, 1'b0);
    apb(1'b1, A_CL, 32'h0003c000);
    rdchk(A_RAW, 32'h00003fff, 1'b0);
    apb(1'b1, A_SET, 32'h0003c000);
    rdchk(A_ST, 32'h0003ffff, 1'b0);
    apb(1'b1, A_EN, 32'h0);
    repeat (2) @(posedge clk);
    `CHK({irq, status_out}, 21'h0)
    apb(1'b1, A_EN, 32'h000fffff);
    apb(1'b1, A_CL, 32'h000fffff);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    // event on the same edge as its clear write: the event wins
    fork
      apb(1'b1, A_CL, 32'h00001000);
      begin
        @(posedge clk);
        hw_event <= 20'h01000;
        @(posedge clk);
        hw_event <= 20'h0;
      end
    join
    rdchk(A_RAW, 32'h00001000, 1'b0);
    // transfer logic updates a buffer word on the edge of a bus write
    fork
      apb(1'b1, 12'h0a8, 32'h0badf00d);
      begin
        @(posedge clk);
        xfer_wr <= '{we: 1'b1, idx: 4'h4, data: 32'h12345678};
        @(posedge clk);
        xfer_wr <= '0;
      end
    join
    rdchk(12'h0a8, 32'h12345678, 1'b0);
    // second reset in mid-run
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    `CHK({irq, status_out}, 21'h0)
    rdchk(A_RAW, 32'h0, 1'b0);
    rdchk(12'h0a8, 32'h0, 1'b0);
    wrap_up();
  end
endmodule
